// ### testbench/binary_pattern_correlator_bench.sv
// Self-checking bench for the binary pattern correlator
`timescale 1ns/1ns
`include "correlator_defines.svh"
`define CHECK(nm, ex, got) \
    begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module binary_pattern_correlator_bench
    import correlator_pkg::*;
;
    logic        clk      = 1'b0;
    logic        rstn     = 1'b0;
    logic        saw_full = 1'b0;
    logic [15:0] pins;
    logic        probe_clk, probe_in, oe_n, flag, p_out, t_out, m_out, ready;
    logic [6:0]  score_out, score_in;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cycles    = 0;
    chain_t      a, t, m, r;
    score_t      want, thr, nthr;

    always #50 clk = ~clk;

    binary_pattern_correlator u_binary_pattern_correlator (
        .I_CLK(clk), .I_RSTN(rstn), .I_PROBE_CLK(probe_clk), .I_PROBE_SERIAL_IN(probe_in),
        .I_TEMPLATE_CLK(pins[`PIN_TMPL_CLK]), .I_TEMPLATE_SERIAL_IN(pins[`PIN_TMPL_IN]),
        .I_MASK_CLK(pins[`PIN_MASK_CLK]), .I_MASK_SERIAL_IN(pins[`PIN_MASK_IN]),
        .I_THRESH_CLK(pins[`PIN_THR_CLK]), .I_SUM_CLK(pins[`PIN_SUM_CLK]),
        .I_REF_LATCH_LOAD(pins[`PIN_REF_LOAD]), .I_OUTPUT_COMPLEMENT(pins[`PIN_COMPL]),
        .I_OUTPUT_FLOAT_CTL(pins[`PIN_FLOAT]), .I_SCORE_PINS(score_in),
        .O_SCORE_PINS(score_out), .O_SCORE_PINS_OE_N(oe_n), .O_LIMIT_REACHED_FLAG(flag),
        .O_PROBE_SERIAL_OUT(p_out), .O_TEMPLATE_SERIAL_OUT(t_out),
        .O_MASK_SERIAL_OUT(m_out), .O_PROBE_READY(ready)
    );
    host_model u_host_model (
        .i_clk(clk), .i_score(score_out), .i_oe_n(oe_n), .i_ready(ready), .o_pins(pins),
        .o_probe_clk(probe_clk), .o_probe_in(probe_in), .o_score(score_in)
    );

    function automatic score_t corr(input chain_t pa, input chain_t pr, input chain_t pm);
        return score_t'($countones(~(pa ^ pr) & pm));
    endfunction : corr

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim

    always @(posedge probe_clk) if (!ready) saw_full <= 1'b1;
    // Whole run needs roughly 5200 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(55692));
        r = '0;
        thr = '0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            t = {$urandom, $urandom};
            m = (i == 0) ? '0 : (i == 1) ? '1 : {$urandom, $urandom};
            a = (i == 1) ? t : {$urandom, $urandom};
            u_host_model.load_chains(t, m);
            `CHECK("template out", t[63], t_out)
            `CHECK("mask out", m[63], m_out)
            u_host_model.send_probe(a);
            repeat (20) @(posedge clk);
            `CHECK("probe out", a[63], p_out)
            u_host_model.s_edges(3);
            want = corr(a, r, m);
            `CHECK("score on held ref", want, score_out)
            u_host_model.put(`PIN_REF_LOAD, 1'b1);
            repeat (8) @(posedge clk);
            u_host_model.put(`PIN_REF_LOAD, 1'b0);
            u_host_model.s_edges(2);
            `CHECK("score two edges after ref", want, score_out)
            r = t;
            u_host_model.s_edges(1);
            want = corr(a, r, m);
            `CHECK("score on new ref", want, score_out)
            `CHECK("flag before load", want >= thr, flag)
            nthr = (want >= thr) ? want + 7'h01 : want;
            u_host_model.load_thr(nthr);
            u_host_model.s_edges(2);
            `CHECK("flag in pipeline", want >= thr, flag)
            u_host_model.s_edges(1);
            thr = nthr;
            `CHECK("flag new limit", want >= thr, flag)
            u_host_model.put(`PIN_COMPL, 1'b1);
            repeat (8) @(posedge clk);
            `CHECK("inverted score", ~want, score_out)
            // Pins now show the inverse, so an accepted load would take the inverted score as threshold
            u_host_model.strobe(16'h1 << `PIN_THR_CLK);
            u_host_model.s_edges(3);
            `CHECK("flag after driven load", want >= thr, flag)
            u_host_model.put(`PIN_COMPL, 1'b0);
            repeat (8) @(posedge clk);
        end
        `CHECK("buffer refused", 1'b1, saw_full)
        end_sim();
    end
endmodule : binary_pattern_correlator_bench

// ### testbench/binary_pattern_correlator_checker.sv
// Pin-level assertions for the binary pattern correlator
`timescale 1ns/1ns
module binary_pattern_correlator_checker (
    input wire logic       I_CLK,
    input wire logic       I_RSTN,
    input wire logic       I_PROBE_CLK,
    input wire logic       I_PROBE_SERIAL_IN,
    input wire logic       I_TEMPLATE_CLK,
    input wire logic       I_TEMPLATE_SERIAL_IN,
    input wire logic       I_MASK_CLK,
    input wire logic       I_MASK_SERIAL_IN,
    input wire logic       I_THRESH_CLK,
    input wire logic       I_SUM_CLK,
    input wire logic       I_REF_LATCH_LOAD,
    input wire logic       I_OUTPUT_COMPLEMENT,
    input wire logic       I_OUTPUT_FLOAT_CTL,
    input wire logic [6:0] I_SCORE_PINS,
    input wire logic [6:0] O_SCORE_PINS,
    input wire logic       O_SCORE_PINS_OE_N,
    input wire logic       O_LIMIT_REACHED_FLAG,
    input wire logic       O_PROBE_SERIAL_OUT,
    input wire logic       O_TEMPLATE_SERIAL_OUT,
    input wire logic       O_MASK_SERIAL_OUT,
    input wire logic       O_PROBE_READY
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    chk_float_off: assert property (I_OUTPUT_FLOAT_CTL [*8] |-> O_SCORE_PINS_OE_N)
        else $error("score drivers still on");
    chk_float_on: assert property (!I_OUTPUT_FLOAT_CTL [*8] |-> !O_SCORE_PINS_OE_N)
        else $error("score drivers still off");
    chk_cmpl_flip: assert property (
        (!I_SUM_CLK && $stable(I_OUTPUT_COMPLEMENT)) [*5]
        ##1 (!I_SUM_CLK && $changed(I_OUTPUT_COMPLEMENT))
        ##1 (!I_SUM_CLK && $stable(I_OUTPUT_COMPLEMENT)) [*7]
        |-> O_SCORE_PINS == ~$past(O_SCORE_PINS, 8))
        else $error("score not inverted");
    chk_score_range: assert property (!I_OUTPUT_COMPLEMENT [*8] |-> O_SCORE_PINS <= 7'h40)
        else $error("true score above full count");
    chk_tmpl_cause: assert property ($changed(O_TEMPLATE_SERIAL_OUT) |->
        $past(I_TEMPLATE_CLK, 3) || $past(I_TEMPLATE_CLK, 4))
        else $error("template chain moved without its clock");
    chk_mask_cause: assert property ($changed(O_MASK_SERIAL_OUT) |->
        $past(I_MASK_CLK, 3) || $past(I_MASK_CLK, 4))
        else $error("mask chain moved without its clock");
    chk_flag_cause: assert property ($changed(O_LIMIT_REACHED_FLAG) |->
        $past(I_SUM_CLK, 3) || $past(I_SUM_CLK, 4))
        else $error("flag moved without a summer edge");
    chk_score_cause: assert property ($changed(O_SCORE_PINS) |->
        $past(I_SUM_CLK, 3) || $past(I_SUM_CLK, 4)
        || $past(I_OUTPUT_COMPLEMENT, 7) != I_OUTPUT_COMPLEMENT)
        else $error("score moved without a summer edge");
endmodule : binary_pattern_correlator_checker

bind binary_pattern_correlator binary_pattern_correlator_checker u_checker (.*);

// ### testbench/host_model.sv
// Host-side model driving the correlator's clocks, serial lines and score pins
`timescale 1ns/1ns
`include "correlator_defines.svh"
module host_model
    import correlator_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic [6:0]  i_score,
    input  wire logic        i_oe_n,
    input  wire logic        i_ready,
    output logic      [15:0] o_pins,
    output logic             o_probe_clk,
    output logic             o_probe_in,
    output logic      [6:0]  o_score
);
    logic       run      = 1'b0;
    logic [6:0] host_val = 7'h00;

    // Wire level: device while enabled, else the host's value
    assign o_score = i_oe_n ? host_val : i_score;
    initial begin
        o_pins = 16'h0000;
        o_probe_clk = 1'b0;
        o_probe_in = 1'b0;
    end
    // Link clock stands still between frames
    always #32 o_probe_clk = run ? ~o_probe_clk : 1'b0;

    task automatic put(input int pos, input logic v);
        @(posedge i_clk);
        o_pins[pos] <= v;
    endtask : put
    // Pins are filtered, so each level is held well past four cycles
    task automatic strobe(input logic [15:0] clks);
        @(posedge i_clk);
        o_pins <= o_pins | clks;
        repeat (5) @(posedge i_clk);
        o_pins <= o_pins & ~clks;
        repeat (5) @(posedge i_clk);
    endtask : strobe
    task automatic s_edges(input int n);
        repeat (n) strobe(16'h1 << `PIN_SUM_CLK);
    endtask : s_edges
    task automatic load_chains(input chain_t t, input chain_t m);
        for (int i = 63; i >= 0; i--) begin
            @(posedge i_clk);
            o_pins[`PIN_TMPL_IN] <= t[i];
            o_pins[`PIN_MASK_IN] <= m[i];
            repeat (4) @(posedge i_clk);
            strobe((16'h1 << `PIN_TMPL_CLK) | (16'h1 << `PIN_MASK_CLK));
        end
    endtask : load_chains
    // A bit counts only at an edge where ready was high
    task automatic send_probe(input chain_t v);
        int i;
        i = 0;
        run = 1'b1;
        while (i < 64) begin
            o_probe_in <= v[63 - i];
            @(posedge o_probe_clk);
            if (i_ready) i++;
        end
        run = 1'b0;
        o_probe_in <= ~o_probe_in;
    endtask : send_probe
    task automatic load_thr(input score_t v);
        put(`PIN_FLOAT, 1'b1);
        repeat (8) @(posedge i_clk);
        host_val <= v;
        repeat (5) @(posedge i_clk);
        strobe(16'h1 << `PIN_THR_CLK);
        host_val <= ~v;
        put(`PIN_FLOAT, 1'b0);
    endtask : load_thr
endmodule : host_model

// ### verilog/binary_pattern_correlator.sv
// Correlator core with its probe-bit crossing FIFO
`timescale 1ns/1ns
`include "correlator_defines.svh"

// ----------------------------------------------------------------------------
// Dual-clock FIFO, gray-coded pointers
// ----------------------------------------------------------------------------
module probe_cdc_fifo #(
    parameter int WIDTH = `PROBE_FIFO_W,
    parameter int DEPTH = `PROBE_FIFO_D,
    parameter int AW    = `FIFO_AW
) (
    input  wire logic             i_wr_clk,
    input  wire logic             i_rd_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_wr_valid,
    input  wire logic [WIDTH-1:0] i_wr_data,
    output logic                  o_wr_ready,
    output logic                  o_rd_valid,
    output logic [WIDTH-1:0]      o_rd_data,
    input  wire logic             i_rd_ready
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wbin_r;
    logic [AW:0]      wgray_r;
    logic [AW:0]      rbin_r;
    logic [AW:0]      rgray_r;
    logic [AW:0]      rg_s1_r;
    logic [AW:0]      rg_s2_r;
    logic [AW:0]      wg_s1_r;
    logic [AW:0]      wg_s2_r;
    logic             full_r;
    logic             empty_r;

    wire              push      = i_wr_valid & ~full_r;
    wire              pop       = i_rd_ready & ~empty_r;
    wire  [AW:0]      wbin_nxt  = wbin_r + (AW+1)'(push);
    wire  [AW:0]      wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
    wire  [AW:0]      rbin_nxt  = rbin_r + (AW+1)'(pop);
    wire  [AW:0]      rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
    wire              full_nxt  = wgray_nxt == {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
    wire              empty_nxt = rgray_nxt == wg_s2_r;

    assign o_wr_ready = ~full_r;
    assign o_rd_valid = ~empty_r;
    assign o_rd_data  = mem_r[rbin_r[AW-1:0]];

    always_ff @(posedge i_wr_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wbin_r  <= '0;
            wgray_r <= '0;
            rg_s1_r <= '0;
            rg_s2_r <= '0;
            full_r  <= 1'b0;
        end else begin
            wbin_r  <= wbin_nxt;
            wgray_r <= wgray_nxt;
            rg_s1_r <= rgray_r;
            rg_s2_r <= rg_s1_r;
            full_r  <= full_nxt;
        end
    end

    // Storage is written only on the link side; the read side sees a slot only
    // after its gray pointer has crossed, so the slot is stable by then
    always_ff @(posedge i_wr_clk) begin
        if (push) begin
            mem_r[wbin_r[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_rd_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rbin_r  <= '0;
            rgray_r <= '0;
            wg_s1_r <= '0;
            wg_s2_r <= '0;
            empty_r <= 1'b1;
        end else begin
            rbin_r  <= rbin_nxt;
            rgray_r <= rgray_nxt;
            wg_s1_r <= wgray_r;
            wg_s2_r <= wg_s1_r;
            empty_r <= empty_nxt;
        end
    end
endmodule : probe_cdc_fifo

// ----------------------------------------------------------------------------
// Correlator top
// ----------------------------------------------------------------------------
// Summary of operation
// - Complement control high presents the inverted 7-bit score on the score pins.
// - Float control high turns all score pin drivers off; low enables them.
// - Threshold loads from score pins only while drivers are floated.
// - Reference-load high copies template into reference latch, tracking while high.
// - Probe chain advances only on its own probe clock; here it shifts on I_CLK as bits leave the FIFO, held on summer edges.
// - Mask chain advances only on its own mask clock.
// - Template chain advances only on its own clock, independent of reference.
// - Threshold captures score pins only on threshold clock rising edge.
// - Summer pipeline advances only on the summer clock.
// - A mask bit of zero forces no-compare at that position.
// - Probe and template are 64-bit chains fed one serial bit at a time.
// - Score appears three summer edges after its alignment.
// - Flag high when score at least threshold; new threshold acts third edge.
// - Position counts one when probe equals reference and mask is one.
// - Threshold clock edge writes the seven driven score pin bits.
module binary_pattern_correlator
    import correlator_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RSTN,
    input  wire logic       I_PROBE_CLK,
    input  wire logic       I_PROBE_SERIAL_IN,
    input  wire logic       I_TEMPLATE_CLK,
    input  wire logic       I_TEMPLATE_SERIAL_IN,
    input  wire logic       I_MASK_CLK,
    input  wire logic       I_MASK_SERIAL_IN,
    input  wire logic       I_THRESH_CLK,
    input  wire logic       I_SUM_CLK,
    input  wire logic       I_REF_LATCH_LOAD,
    input  wire logic       I_OUTPUT_COMPLEMENT,
    input  wire logic       I_OUTPUT_FLOAT_CTL,
    input  wire logic [6:0] I_SCORE_PINS,
    output logic      [6:0] O_SCORE_PINS,
    output logic            O_SCORE_PINS_OE_N,
    output logic            O_LIMIT_REACHED_FLAG,
    output logic            O_PROBE_SERIAL_OUT,
    output logic            O_TEMPLATE_SERIAL_OUT,
    output logic            O_MASK_SERIAL_OUT,
    output logic            O_PROBE_READY
);
    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic part_t ones8(input logic [7:0] v);
        part_t n;
        n = '0;
        for (int i = 0; i < `GROUP_W; i++) begin
            n = n + part_t'(v[i]);
        end
        return n;
    endfunction : ones8

    function automatic chain_t shift_in(input chain_t c, input logic b);
        return {c[`CHAIN_LEN-2:0], b};
    endfunction : shift_in

    // ------------------------------------------------------------------------
    // Pin sampling: three stages, a change counts once stages two and three agree
    // ------------------------------------------------------------------------
    logic [`PIN_CNT-1:0] s1_r;
    logic [`PIN_CNT-1:0] s2_r;
    logic [`PIN_CNT-1:0] s3_r;
    logic [`PIN_CNT-1:0] lvl_r;

    wire  [`PIN_CNT-1:0] pins_in = {I_SCORE_PINS, I_OUTPUT_FLOAT_CTL, I_OUTPUT_COMPLEMENT,
                                    I_REF_LATCH_LOAD, I_MASK_SERIAL_IN, I_TEMPLATE_SERIAL_IN,
                                    I_SUM_CLK, I_THRESH_CLK, I_MASK_CLK, I_TEMPLATE_CLK};
    wire  [`PIN_CNT-1:0] agree   = ~(s2_r ^ s3_r);
    wire  [`PIN_CNT-1:0] lvl_nxt = (agree & s3_r) | (~agree & lvl_r);
    wire  [`PIN_CNT-1:0] rise    = lvl_nxt & ~lvl_r;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            lvl_r <= '0;
        end else begin
            s1_r  <= pins_in;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    wire    tmpl_edge = rise[`PIN_TMPL_CLK];
    wire    mask_edge = rise[`PIN_MASK_CLK];
    wire    thr_edge  = rise[`PIN_THR_CLK];
    wire    sum_edge  = rise[`PIN_SUM_CLK];
    wire    tmpl_bit  = lvl_nxt[`PIN_TMPL_IN];
    wire    mask_bit  = lvl_nxt[`PIN_MASK_IN];
    wire    ref_load  = lvl_r[`PIN_REF_LOAD];
    wire    compl_on  = lvl_r[`PIN_COMPL];
    wire    float_on  = lvl_r[`PIN_FLOAT];
    wire    [6:0] score_in = lvl_nxt[`PIN_SCORE_LO +: `SCORE_W];

    // ------------------------------------------------------------------------
    // Probe path: link-clock capture, crossed through the FIFO
    // ------------------------------------------------------------------------
    logic   probe_valid;
    logic   probe_bit;
    // Hold the probe chain still while the summer samples it
    wire    probe_take = ~sum_edge;
    wire    probe_pop  = probe_valid & probe_take;

    probe_cdc_fifo #(
        .WIDTH (`PROBE_FIFO_W),
        .DEPTH (`PROBE_FIFO_D),
        .AW    (`FIFO_AW)
    ) u_probe_fifo (
        .i_wr_clk   (I_PROBE_CLK),
        .i_rd_clk   (I_CLK),
        .i_rstn     (I_RSTN),
        .i_wr_valid (1'b1),
        .i_wr_data  (I_PROBE_SERIAL_IN),
        .o_wr_ready (O_PROBE_READY),
        .o_rd_valid (probe_valid),
        .o_rd_data  (probe_bit),
        .i_rd_ready (probe_take)
    );

    // ------------------------------------------------------------------------
    // Shift chains and reference latch
    // ------------------------------------------------------------------------
    chain_t probe_r;
    chain_t tmpl_r;
    chain_t mask_r;
    chain_t ref_r;
    score_t thresh_r;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            probe_r  <= `CHAIN_RST;
            tmpl_r   <= `CHAIN_RST;
            mask_r   <= `CHAIN_RST;
            ref_r    <= `CHAIN_RST;
            thresh_r <= `SCORE_RST;
        end else begin
            if (probe_pop) begin
                probe_r <= shift_in(probe_r, probe_bit);
            end
            if (tmpl_edge) begin
                tmpl_r <= shift_in(tmpl_r, tmpl_bit);
            end
            if (mask_edge) begin
                mask_r <= shift_in(mask_r, mask_bit);
            end
            if (ref_load) begin
                ref_r <= tmpl_r;
            end
            if (thr_edge && float_on) begin
                thresh_r <= score_in;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Three-stage summer with threshold carried alongside
    // ------------------------------------------------------------------------
    chain_t hit_r;
    part_t  part_r [`GROUP_CNT];
    score_t thr_p1_r;
    score_t thr_p2_r;
    score_t sum_r;
    logic   flag_r;
    score_t sum_nxt;

    // Unmasked positions count where probe equals reference
    wire    chain_t hit_nxt = ~(probe_r ^ ref_r) & mask_r;

    always_comb begin
        sum_nxt = '0;
        for (int g = 0; g < `GROUP_CNT; g++) begin
            sum_nxt = sum_nxt + score_t'(part_r[g]);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            hit_r    <= `CHAIN_RST;
            thr_p1_r <= `SCORE_RST;
            thr_p2_r <= `SCORE_RST;
            sum_r    <= `SCORE_RST;
            flag_r   <= 1'b0;
            for (int g = 0; g < `GROUP_CNT; g++) begin
                part_r[g] <= '0;
            end
        end else if (sum_edge) begin
            hit_r    <= hit_nxt;
            thr_p1_r <= thresh_r;
            for (int g = 0; g < `GROUP_CNT; g++) begin
                part_r[g] <= ones8(hit_r[g*`GROUP_W +: `GROUP_W]);
            end
            thr_p2_r <= thr_p1_r;
            sum_r    <= sum_nxt;
            flag_r   <= sum_nxt >= thr_p2_r;
        end
    end

    // ------------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------------
    wire    score_t score_fmt = sum_r ^ {`SCORE_W{compl_on}};

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_SCORE_PINS          <= `SCORE_RST;
            O_SCORE_PINS_OE_N     <= 1'b1;
            O_LIMIT_REACHED_FLAG  <= 1'b0;
            O_PROBE_SERIAL_OUT    <= 1'b0;
            O_TEMPLATE_SERIAL_OUT <= 1'b0;
            O_MASK_SERIAL_OUT     <= 1'b0;
        end else begin
            O_SCORE_PINS          <= score_fmt;
            O_SCORE_PINS_OE_N     <= float_on;
            O_LIMIT_REACHED_FLAG  <= flag_r;
            O_PROBE_SERIAL_OUT    <= probe_r[`CHAIN_LEN-1];
            O_TEMPLATE_SERIAL_OUT <= tmpl_r[`CHAIN_LEN-1];
            O_MASK_SERIAL_OUT     <= mask_r[`CHAIN_LEN-1];
        end
    end
endmodule : binary_pattern_correlator

// ### verilog/correlator_defines.svh
// Constants for the binary pattern correlator: widths, depths, pin-vector bit positions
`ifndef CORRELATOR_DEFINES_SVH
`define CORRELATOR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------------------
`define CHAIN_LEN      64
`define SCORE_W        7
`define GROUP_W        8
`define GROUP_CNT      8
`define PART_W         4
`define PROBE_FIFO_W   1
`define PROBE_FIFO_D   8
`define FIFO_AW        3

// ----------------------------------------------------------------------------
// Bit positions in the sampled pin vector
// ----------------------------------------------------------------------------
`define PIN_CNT        16
`define PIN_TMPL_CLK   0
`define PIN_MASK_CLK   1
`define PIN_THR_CLK    2
`define PIN_SUM_CLK    3
`define PIN_TMPL_IN    4
`define PIN_MASK_IN    5
`define PIN_REF_LOAD   6
`define PIN_COMPL      7
`define PIN_FLOAT      8
`define PIN_SCORE_LO   9

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CHAIN_RST      64'h0000000000000000
`define SCORE_RST      7'h00

`endif

// ### verilog/correlator_pkg.sv
// Types shared by the correlator design
package correlator_pkg;
    typedef logic [63:0] chain_t;
    typedef logic [6:0]  score_t;
    typedef logic [3:0]  part_t;
endpackage : correlator_pkg
